// ---- logic/dispatch_scheduler.sv ----
/*
 out-of-order dispatch scheduler: micro-op wait queue, wakeup, bypass
 penalties, transfer micro-op insertion and per-port oldest-first select.
 assumes rename/allocate drives one micro-op per cycle with sequence
 numbers taken from o_alloc_seq, and clusters broadcast result tags.
*/
// Summary of operation
// RULE1 - wait queue holds sixty, refuses when full
// RULE2 - up to eight ready micro-ops per cycle
// RULE3 - each port takes one micro-op per cycle
// RULE4 - every micro-op leaves by exactly one port
// RULE5 - basic integer ops on ports 0,1,5,6
// RULE6 - shift, rotate, carry-add on ports 0,6
// RULE7 - slow integer ops on port 1 only
// RULE8 - bit manipulation, address arithmetic: ports 1,5
// RULE9 - vector logic and blend on 0,1,5
// RULE10 - vector integer arithmetic on ports 1,5
// RULE11 - shuffle, float moves, cipher on port 5
// RULE12 - divider, vector shift, vector misc on 0
// RULE13 - float add port 1; multiply ports 0,1
// RULE14 - branches ports 6,0; port 7 store-address
// RULE15 - ports 2,3 load/store address; 4 store data
// RULE16 - cross-stack sources add forwarding delay (code adds none between vector integer and legacy)
// RULE17 - vector integer/float low: one extra cycle
// RULE18 - some crossings insert a port-using transfer
// RULE19 - integer to legacy upper: port 5, +3
// RULE20 - vector/float to integer: port 1 transfer
// RULE21 - oldest ready micro-op wins each port
// RULE22 - dispatch frees entry; flush drops younger ones
module dispatch_scheduler (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_alloc_valid,
   input wire logic [3:0] i_alloc_cls,
   input wire logic [1:0] i_alloc_dom,
   input wire logic [6:0] i_alloc_dest,
   input wire logic [1:0][6:0] i_alloc_src_tag,
   input wire logic [1:0] i_alloc_src_rdy,
   output logic o_alloc_ready,
   output logic [7:0] o_alloc_seq,
   input wire logic i_wake_valid,
   input wire logic [6:0] i_wake_tag,
   input wire logic [1:0] i_wake_dom,
   input wire logic [7:0] i_port_ready,
   input wire logic i_flush,
   input wire logic [7:0] i_flush_seq,
   output logic [7:0] o_issue_valid,
   output logic [7:0] o_issue_xfer,
   output logic [7:0][6:0] o_issue_tag,
   output logic [7:0][3:0] o_issue_cls,
   output logic [5:0] o_occupancy
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      sched_pkg::entry_s [sched_pkg::ENTRIES-1:0] q;
      logic [5:0] count;
      logic [7:0] seq;
      logic [7:0] iss_valid;
      logic [7:0] iss_xfer;
      logic [7:0][6:0] iss_tag;
      logic [7:0][3:0] iss_cls;
   } state_s;

   state_s state_r;
   state_s state_nxt;
   logic [sched_pkg::ENTRIES-1:0] taken;
   logic found;
   logic [5:0] best;
   logic [5:0] free_idx;
   logic free_ok;
   logic [7:0] req;
   sched_pkg::bypass_s byp;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] class_ports(input logic [3:0] cls);
      logic [7:0] m;
      m = 8'h00;
      unique case (cls)
         sched_pkg::CLS_ALU: m = sched_pkg::PM_ALU; // RULE5
         sched_pkg::CLS_SHIFT: m = sched_pkg::PM_SHIFT; // RULE6
         sched_pkg::CLS_SLOW_INT: m = sched_pkg::PM_SLOW_INT; // RULE7
         sched_pkg::CLS_BIT_MANIP: m = sched_pkg::PM_BIT_MANIP; // RULE8
         sched_pkg::CLS_VEC_LOGIC: m = sched_pkg::PM_VEC_LOGIC; // RULE9
         sched_pkg::CLS_VEC_ARITH: m = sched_pkg::PM_VEC_ARITH; // RULE10
         sched_pkg::CLS_SHUFFLE: m = sched_pkg::PM_SHUFFLE; // RULE11
         sched_pkg::CLS_PORT0_ONLY: m = sched_pkg::PM_PORT0_ONLY; // RULE12
         sched_pkg::CLS_FP_ADD: m = sched_pkg::PM_FP_ADD; // RULE13
         sched_pkg::CLS_FMA: m = sched_pkg::PM_FMA; // RULE13
         sched_pkg::CLS_BRANCH: m = sched_pkg::PM_BRANCH; // RULE14
         sched_pkg::CLS_STORE_ADDR: m = sched_pkg::PM_STORE_ADDR; // RULE14
         sched_pkg::CLS_LOAD: m = sched_pkg::PM_LOAD; // RULE15
         sched_pkg::CLS_STORE_DATA: m = sched_pkg::PM_STORE_DATA; // RULE15
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // producer domain to consumer domain crossing cost
   function automatic sched_pkg::bypass_s bypass(input logic [1:0] from, input logic [1:0] to);
      sched_pkg::bypass_s b;
      b = '0;
      if (from != to) begin
         if (from == sched_pkg::DOM_INT) begin
            b.xfer = 1'b1; // RULE18
            b.port = sched_pkg::XFER_PORT_FROM_INT; // RULE19
            if (to == sched_pkg::DOM_LEGACY) begin
               b.dly = sched_pkg::DLY_LEGACY_INT; // RULE19
            end
         end else if (to == sched_pkg::DOM_INT) begin
            b.xfer = 1'b1; // RULE20
            b.port = sched_pkg::XFER_PORT_TO_INT; // RULE20
            if (from == sched_pkg::DOM_LEGACY) begin
               b.dly = sched_pkg::DLY_LEGACY_INT; // RULE20
            end
         end else if ((from == sched_pkg::DOM_VEC_FLT) || (to == sched_pkg::DOM_VEC_FLT)) begin
            if ((from == sched_pkg::DOM_LEGACY) || (to == sched_pkg::DOM_LEGACY)) begin
               b.xfer = 1'b1; // RULE18
               b.port = sched_pkg::XFER_PORT_FROM_INT;
               b.dly = sched_pkg::DLY_LEGACY_VEC; // RULE16
            end else begin
               b.dly = sched_pkg::DLY_VEC_CROSS; // RULE17
            end
         end
      end
      return b;
   endfunction

   // which ports an entry may use this cycle; a pending transfer blocks the op itself
   function automatic logic [7:0] entry_ports(input sched_pkg::entry_s en);
      logic [7:0] m;
      sched_pkg::bypass_s b;
      m = 8'h00;
      b = '0;
      if (en.valid) begin
         if (en.src_xfer[0]) begin
            b = bypass(en.src_from[0], en.dom);
            m[b.port] = 1'b1; // RULE18
         end else if (en.src_xfer[1]) begin
            b = bypass(en.src_from[1], en.dom);
            m[b.port] = 1'b1; // RULE18
         end else if (&en.src_rdy && (en.dly == sched_pkg::DLY_NONE)) begin
            m = class_ports(en.cls); // RULE2
         end
      end
      return m;
   endfunction

   // larger distance from the allocation pointer means older
   function automatic logic older(input logic [7:0] a, input logic [7:0] b, input logic [7:0] head);
      return 8'(head - a) > 8'(head - b);
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      taken = '0;
      found = 1'b0;
      best = 6'h00;
      free_idx = 6'h00;
      free_ok = 1'b0;
      req = 8'h00;
      byp = '0;
      state_nxt.iss_valid = 8'h00;
      state_nxt.iss_xfer = 8'h00;

      for (int e = 0; e < sched_pkg::ENTRIES; e++) begin
         if (state_r.q[e].dly != sched_pkg::DLY_NONE) begin
            state_nxt.q[e].dly = 2'(state_r.q[e].dly - 2'h1); // RULE16
         end
         if (!state_r.q[e].valid && !free_ok) begin
            free_ok = 1'b1;
            free_idx = 6'(e);
         end
      end

      // allocation; full queue leaves o_alloc_ready low
      if (i_alloc_valid && o_alloc_ready && free_ok) begin
         state_nxt.q[free_idx] = '0; // RULE1
         state_nxt.q[free_idx].valid = 1'b1;
         state_nxt.q[free_idx].cls = i_alloc_cls;
         state_nxt.q[free_idx].dom = i_alloc_dom;
         state_nxt.q[free_idx].dest = i_alloc_dest;
         state_nxt.q[free_idx].src_tag = i_alloc_src_tag;
         state_nxt.q[free_idx].src_rdy = i_alloc_src_rdy;
         state_nxt.q[free_idx].seq = state_r.seq;
         state_nxt.seq = 8'(state_r.seq + 8'h01);
      end

      // wakeup also catches the entry written this cycle
      if (i_wake_valid) begin
         for (int e = 0; e < sched_pkg::ENTRIES; e++) begin
            for (int s = 0; s < 2; s++) begin
               if (state_nxt.q[e].valid && !state_nxt.q[e].src_rdy[s] &&
                   (state_nxt.q[e].src_tag[s] == i_wake_tag)) begin
                  byp = bypass(i_wake_dom, state_nxt.q[e].dom);
                  state_nxt.q[e].src_rdy[s] = 1'b1;
                  state_nxt.q[e].src_from[s] = i_wake_dom;
                  state_nxt.q[e].src_xfer[s] = byp.xfer; // RULE18
                  if (!byp.xfer && (byp.dly > state_nxt.q[e].dly)) begin
                     state_nxt.q[e].dly = byp.dly; // RULE17
                  end
               end
            end
         end
      end

      // per-port pick: each entry goes to at most one port, oldest first
      for (int p = 0; p < sched_pkg::PORTS; p++) begin
         found = 1'b0;
         best = 6'h00;
         for (int e = 0; e < sched_pkg::ENTRIES; e++) begin
            req = entry_ports(state_r.q[e]);
            if (i_port_ready[p] && req[p] && !taken[e] && // RULE3
                (!found || older(state_r.q[e].seq, state_r.q[best].seq, state_r.seq))) begin // RULE21
               found = 1'b1;
               best = 6'(e);
            end
         end
         if (found) begin
            taken[best] = 1'b1; // RULE4
            state_nxt.iss_valid[p] = 1'b1; // RULE2
            state_nxt.iss_tag[p] = state_r.q[best].dest;
            state_nxt.iss_cls[p] = state_r.q[best].cls;
            if (|state_r.q[best].src_xfer) begin
               state_nxt.iss_xfer[p] = 1'b1; // RULE18
               if (state_r.q[best].src_xfer[0]) begin
                  byp = bypass(state_r.q[best].src_from[0], state_r.q[best].dom);
                  state_nxt.q[best].src_xfer[0] = 1'b0;
               end else begin
                  byp = bypass(state_r.q[best].src_from[1], state_r.q[best].dom);
                  state_nxt.q[best].src_xfer[1] = 1'b0;
               end
               if (byp.dly > state_nxt.q[best].dly) begin
                  state_nxt.q[best].dly = byp.dly; // RULE19
               end
            end else begin
               state_nxt.q[best].valid = 1'b0; // RULE22
            end
         end
      end

      // flush drops everything younger than the given sequence number
      if (i_flush) begin
         for (int e = 0; e < sched_pkg::ENTRIES; e++) begin
            if ($signed(8'(state_nxt.q[e].seq - i_flush_seq)) > 0) begin
               state_nxt.q[e].valid = 1'b0; // RULE22
            end
         end
         state_nxt.seq = 8'(i_flush_seq + 8'h01);
      end

      state_nxt.count = 6'h00;
      for (int e = 0; e < sched_pkg::ENTRIES; e++) begin
         state_nxt.count = 6'(state_nxt.count + {5'h00, state_nxt.q[e].valid});
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_alloc_ready = state_r.count < sched_pkg::ENTRIES_CNT; // RULE1
   assign o_alloc_seq = state_r.seq;
   assign o_issue_valid = state_r.iss_valid;
   assign o_issue_xfer = state_r.iss_xfer;
   assign o_issue_tag = state_r.iss_tag;
   assign o_issue_cls = state_r.iss_cls;
   assign o_occupancy = state_r.count;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   queue_full_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
      (o_occupancy == sched_pkg::ENTRIES_CNT) |-> !o_alloc_ready)
      else $error("allocation open while queue full");

   queue_bound_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
      o_occupancy <= sched_pkg::ENTRIES_CNT)
      else $error("occupancy above sixty");

   alloc_count_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE22
      (i_alloc_valid && o_alloc_ready && !i_flush && (i_port_ready == 8'h00))
      |=> (o_occupancy == 6'($past(o_occupancy) + 6'h01)))
      else $error("allocation did not take one entry");

   xfer_port_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE20
      (o_issue_xfer & 8'hdd) == 8'h00)
      else $error("transfer micro-op off ports 1 and 5");

   port7_store_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE14
      o_issue_valid[7] |-> (o_issue_cls[7] == sched_pkg::CLS_STORE_ADDR))
      else $error("port 7 carried a non store-address op");

   port4_data_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE15
      (o_issue_valid[4] && !o_issue_xfer[4]) |-> (o_issue_cls[4] == sched_pkg::CLS_STORE_DATA))
      else $error("port 4 carried a non store-data op");

   xfer_valid_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE18
      (o_issue_xfer & ~o_issue_valid) == 8'h00)
      else $error("transfer flag without an issue");

   full_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
      (!o_alloc_ready && (i_port_ready == 8'h00) && !i_flush)
      |=> (o_occupancy == $past(o_occupancy)))
      else $error("full queue changed without a dispatch");

   alloc_seq_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE21
      (i_alloc_valid && o_alloc_ready && !i_flush)
      |=> (o_alloc_seq == 8'($past(o_alloc_seq) + 8'h01)))
      else $error("sequence number did not advance");

   flush_seq_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE22
      i_flush |=> (o_alloc_seq == 8'($past(i_flush_seq) + 8'h01)))
      else $error("sequence not rewound by flush");

   issue_free_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE22
      (!i_alloc_valid && !i_flush)
      |=> (o_occupancy == 6'($past(o_occupancy) - 6'($countones(o_issue_valid & ~o_issue_xfer)))))
      else $error("dispatched entry not released");

   for (genvar p = 0; p < 8; p++) begin : g_port_chk
      issue_ready_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
         o_issue_valid[p] |-> $past(i_port_ready[p]))
         else $error("issue on a port that was not ready");

      issue_legal_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
         (o_issue_valid[p] && !o_issue_xfer[p]) |-> ((class_ports(o_issue_cls[p]) & (8'h01 << p)) != 8'h00))
         else $error("micro-op issued on a port its class lacks");

      slow_int_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
         (o_issue_valid[p] && !o_issue_xfer[p] && (o_issue_cls[p] == sched_pkg::CLS_SLOW_INT))
         |-> (p == 1))
         else $error("slow integer op off port 1");
   end
endmodule

// ---- shared/sched_pkg.sv ----
/*
 package for the out-of-order dispatch scheduler: sizes, domain and class
 codes, port masks and bypass penalties.
 assumes one core clock and upstream logic that uses these same codes.
*/
package sched_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int unsigned ENTRIES = 60;
   localparam int unsigned PORTS = 8;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned TAG_W = 7;
   localparam int unsigned SEQ_W = 8;
   localparam int unsigned CLS_W = 4;
   localparam int unsigned DOM_W = 2;
   localparam int unsigned DLY_W = 2;
   localparam logic [IDX_W-1:0] ENTRIES_CNT = 6'h3c;

   // ---------------------------------------------------------------
   // execution domains
   // ---------------------------------------------------------------
   localparam logic [1:0] DOM_INT = 2'h0;
   localparam logic [1:0] DOM_VEC_INT = 2'h1;
   localparam logic [1:0] DOM_VEC_FLT = 2'h2;
   localparam logic [1:0] DOM_LEGACY = 2'h3;

   // ---------------------------------------------------------------
   // bypass penalties and transfer ports
   // ---------------------------------------------------------------
   localparam logic [1:0] DLY_NONE = 2'h0;
   localparam logic [1:0] DLY_VEC_CROSS = 2'h1;
   localparam logic [1:0] DLY_LEGACY_INT = 2'h3;
   localparam logic [1:0] DLY_LEGACY_VEC = 2'h1;
   localparam logic [2:0] XFER_PORT_TO_INT = 3'h1;
   localparam logic [2:0] XFER_PORT_FROM_INT = 3'h5;

   // ---------------------------------------------------------------
   // micro-op classes
   // ---------------------------------------------------------------
   localparam logic [3:0] CLS_ALU = 4'h0;
   localparam logic [3:0] CLS_SHIFT = 4'h1;
   localparam logic [3:0] CLS_SLOW_INT = 4'h2;
   localparam logic [3:0] CLS_BIT_MANIP = 4'h3;
   localparam logic [3:0] CLS_VEC_LOGIC = 4'h4;
   localparam logic [3:0] CLS_VEC_ARITH = 4'h5;
   localparam logic [3:0] CLS_SHUFFLE = 4'h6;
   localparam logic [3:0] CLS_PORT0_ONLY = 4'h7;
   localparam logic [3:0] CLS_FP_ADD = 4'h8;
   localparam logic [3:0] CLS_FMA = 4'h9;
   localparam logic [3:0] CLS_BRANCH = 4'ha;
   localparam logic [3:0] CLS_STORE_ADDR = 4'hb;
   localparam logic [3:0] CLS_LOAD = 4'hc;
   localparam logic [3:0] CLS_STORE_DATA = 4'hd;

   // ---------------------------------------------------------------
   // port masks, bit n is port n
   // ---------------------------------------------------------------
   localparam logic [7:0] PM_ALU = 8'h63;
   localparam logic [7:0] PM_SHIFT = 8'h41;
   localparam logic [7:0] PM_SLOW_INT = 8'h02;
   localparam logic [7:0] PM_BIT_MANIP = 8'h22;
   localparam logic [7:0] PM_VEC_LOGIC = 8'h23;
   localparam logic [7:0] PM_VEC_ARITH = 8'h22;
   localparam logic [7:0] PM_SHUFFLE = 8'h20;
   localparam logic [7:0] PM_PORT0_ONLY = 8'h01;
   localparam logic [7:0] PM_FP_ADD = 8'h02;
   localparam logic [7:0] PM_FMA = 8'h03;
   localparam logic [7:0] PM_BRANCH = 8'h41;
   localparam logic [7:0] PM_STORE_ADDR = 8'h8c;
   localparam logic [7:0] PM_LOAD = 8'h0c;
   localparam logic [7:0] PM_STORE_DATA = 8'h10;

   typedef struct packed {
      logic valid;
      logic [3:0] cls;
      logic [1:0] dom;
      logic [6:0] dest;
      logic [1:0][6:0] src_tag;
      logic [1:0] src_rdy;
      logic [1:0] src_xfer;
      logic [1:0][1:0] src_from;
      logic [1:0] dly;
      logic [7:0] seq;
   } entry_s;

   typedef struct packed {
      logic xfer;
      logic [2:0] port;
      logic [1:0] dly;
   } bypass_s;
endpackage

// ---- verif/exec_cluster_model.sv ----
/*
 model of the execution clusters beyond the scheduler: per-port back-pressure
 and the result broadcast that wakes waiting micro-ops.
 assumes the bench commands stalls and broadcasts just after a falling edge.
*/
module exec_cluster_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_stall,
   input wire logic i_bcast,
   input wire logic [6:0] i_bcast_tag,
   input wire logic [1:0] i_bcast_dom,
   output logic [7:0] o_port_ready,
   output logic o_wake_valid,
   output logic [6:0] o_wake_tag,
   output logic [1:0] o_wake_dom
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] last_r;
   // ---------------------------------------------------------------
   // ports and broadcast
   // ---------------------------------------------------------------
   // a busy cluster refuses its port until the stall is lifted
   assign o_port_ready = i_rst ? 8'h00 : ~i_stall;
   assign o_wake_valid = i_bcast & ~i_rst;
   // idle tag bus shows the inverse of the last tag so a stale value never matches
   assign o_wake_tag = i_bcast ? i_bcast_tag : ~last_r;
   assign o_wake_dom = i_bcast ? i_bcast_dom : ~i_bcast_dom;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         last_r <= 7'h00;
      end else if (i_bcast) begin
         last_r <= i_bcast_tag;
      end
   end
endmodule

// ---- verif/ooo_dispatch_port_scheduler_bench.sv ----
/*
 self-checking bench for the dispatch scheduler: routing, fill, ordering,
 bypass delays, transfer insertion and flush.
 assumes the scheduler and the cluster model; inputs change at falling edges.
*/
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("mismatch %0t %s", $time, m); end end
module ooo_dispatch_port_scheduler_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, av, bc, fl;
   logic [3:0] acls;
   logic [1:0] adom, ardy, bcdom, wdom;
   logic [6:0] adest, bctag, wtag;
   logic [1:0][6:0] asrc;
   logic [7:0] stall, pready, flseq, o_alloc_seq, o_issue_valid, o_issue_xfer;
   logic o_alloc_ready, wvalid;
   logic [7:0][6:0] o_issue_tag;
   logic [7:0][3:0] o_issue_cls;
   logic [5:0] o_occupancy;
   int error_cnt, check_count, cyc;
   // ---------------------------------------------------------------
   // clock, instances
   // ---------------------------------------------------------------
   always #2 clk = ~clk;
   dispatch_scheduler dispatch_scheduler_i (.i_clk(clk), .i_rst(rst), .i_alloc_valid(av), .i_alloc_cls(acls),
      .i_alloc_dom(adom), .i_alloc_dest(adest), .i_alloc_src_tag(asrc), .i_alloc_src_rdy(ardy),
      .o_alloc_ready(o_alloc_ready), .o_alloc_seq(o_alloc_seq), .i_wake_valid(wvalid), .i_wake_tag(wtag),
      .i_wake_dom(wdom), .i_port_ready(pready), .i_flush(fl), .i_flush_seq(flseq),
      .o_issue_valid(o_issue_valid), .o_issue_xfer(o_issue_xfer), .o_issue_tag(o_issue_tag),
      .o_issue_cls(o_issue_cls), .o_occupancy(o_occupancy));
   exec_cluster_model exec_cluster_model_i (.i_clk(clk), .i_rst(rst), .i_stall(stall), .i_bcast(bc),
      .i_bcast_tag(bctag), .i_bcast_dom(bcdom), .o_port_ready(pready), .o_wake_valid(wvalid),
      .o_wake_tag(wtag), .o_wake_dom(wdom));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic test_done();
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // held until taken; the caller either allocates again or calls idle
   task automatic alloc(input logic [3:0] c, input logic [1:0] d, input logic [6:0] t, input logic [1:0] r);
      @(negedge clk);
      av = 1'b1;
      acls = c;
      adom = d;
      adest = t;
      ardy = r;
      while (o_alloc_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
   endtask
   task automatic idle();
      @(negedge clk);
      av = 1'b0;
   endtask
   task automatic watch(input int lim, output logic [7:0] v, output int k);
      k = 0;
      v = 8'h00;
      while (k < lim && v === 8'h00) begin
         @(negedge clk);
         k++;
         v = o_issue_valid;
      end
   endtask
   function automatic int pidx(input logic [7:0] v);
      pidx = 0;
      for (int i = 0; i < 8; i++) if (v[i] === 1'b1) pidx = i;
   endfunction
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      `CHK(o_alloc_ready, 1'b1, "not ready after reset")
      `CHK(o_occupancy, 6'h00, "queue not empty after reset")
      `CHK(o_issue_valid, 8'h00, "issue after reset")
   endtask
   task automatic t_route();
      logic [7:0] m [14] = '{8'h63, 8'h41, 8'h02, 8'h22, 8'h23, 8'h22, 8'h20, 8'h01, 8'h02, 8'h03, 8'h41,
         8'h8c, 8'h0c, 8'h10};
      logic [7:0] v;
      int k;
      for (int i = 0; i < 14; i++) begin
         stall = m[i];
         alloc(4'(i), sched_pkg::DOM_INT, 7'(40 + i), 2'b11);
         idle();
         watch(6, v, k);
         `CHK(v, 8'h00, "issue on a foreign port")
         stall = 8'h00;
         watch(10, v, k);
         `CHK(v & ~m[i], 8'h00, "wrong port")
         `CHK(v & (v - 8'h01), 8'h00, "op on two ports")
         `CHK(o_issue_tag[pidx(v)], 7'(40 + i), "wrong tag issued")
         `CHK(o_issue_cls[pidx(v)], 4'(i), "wrong class issued")
      end
   endtask
   task automatic t_oldest();
      logic [7:0] v;
      int k;
      stall = 8'hff;
      for (int j = 0; j < 3; j++) alloc(sched_pkg::CLS_SLOW_INT, sched_pkg::DOM_INT, 7'(21 + j), 2'b11);
      idle();
      stall = 8'hfd;
      for (int j = 0; j < 3; j++) begin
         watch(10, v, k);
         `CHK(v, 8'h02, "port took more than one")
         `CHK(o_issue_tag[1], 7'(21 + j), "not oldest first")
      end
      stall = 8'h00;
   endtask
   task automatic t_fill();
      int n;
      stall = 8'hff;
      for (int i = 0; i < 60; i++) alloc(4'(i % 14), sched_pkg::DOM_INT, 7'(i), 2'b11);
      idle();
      `CHK(o_alloc_ready, 1'b0, "ready when full")
      `CHK(o_occupancy, 6'h3c, "full count")
      @(negedge clk);
      av = 1'b1;
      repeat (3) @(negedge clk);
      av = 1'b0;
      `CHK(o_occupancy, 6'h3c, "op taken when full")
      stall = 8'h00;
      n = 0;
      repeat (100) begin
         @(negedge clk);
         n += $countones(o_issue_valid);
      end
      `CHK(n, 60, "drain count")
      `CHK(o_occupancy, 6'h00, "entries not freed")
   endtask
   task automatic t_wake();
      logic [3:0] c [6] = '{sched_pkg::CLS_FMA, sched_pkg::CLS_FMA, sched_pkg::CLS_VEC_ARITH, sched_pkg::CLS_ALU,
         sched_pkg::CLS_FMA, sched_pkg::CLS_ALU};
      logic [1:0] cd [6] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h3, 2'h0};
      logic [1:0] wd [6] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
      int kx [6] = '{1, 2, 2, 0, 0, 0};
      logic [7:0] xp [6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h20, 8'h02};
      int g [6];
      logic [7:0] v;
      int k;
      for (int i = 0; i < 6; i++) begin
         alloc(c[i], cd[i], 7'h30, 2'b10);
         idle();
         watch(4, v, k);
         `CHK(v, 8'h00, "issue before operand ready")
         @(negedge clk);
         bc = 1'b1;
         bctag = 7'h0a;
         bcdom = wd[i];
         @(negedge clk);
         bc = 1'b0;
         watch(20, v, k);
         g[i] = 0;
         if (kx[i] != 0) begin
            `CHK(k, kx[i], "bypass delay")
         end else begin
            `CHK(o_issue_xfer, xp[i], "transfer port")
            `CHK(o_issue_tag[pidx(v)], 7'h30, "transfer tag")
            watch(20, v, g[i]);
         end
         `CHK(o_issue_xfer, 8'h00, "consumer marked as transfer")
         `CHK(o_issue_tag[pidx(v)], 7'h30, "consumer tag")
      end
      `CHK(g[4] - g[3], 3, "integer to upper delay")
      `CHK(g[5] - g[3], 3, "upper to integer delay")
   endtask
   task automatic t_flush();
      logic [7:0] s;
      int n;
      stall = 8'hff;
      @(negedge clk);
      s = o_alloc_seq;
      for (int i = 0; i < 4; i++) alloc(sched_pkg::CLS_ALU, sched_pkg::DOM_INT, 7'(60 + i), 2'b11);
      idle();
      fl = 1'b1;
      flseq = s + 8'h01;
      @(negedge clk);
      fl = 1'b0;
      @(negedge clk);
      `CHK(o_occupancy, 6'h02, "younger ops kept")
      `CHK(o_alloc_seq, s + 8'h02, "sequence after flush")
      stall = 8'h00;
      n = 0;
      repeat (10) begin
         @(negedge clk);
         n += $countones(o_issue_valid);
      end
      `CHK(n, 2, "survivors issued")
   endtask
   // ---------------------------------------------------------------
   // main sequence and timeout
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      {clk, av, bc, fl, acls, adom, ardy, bcdom, adest, bctag, flseq, stall} = '0;
      asrc[0] = 7'h0a;
      asrc[1] = 7'h0b;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset();
      t_route();
      t_oldest();
      t_fill();
      t_wake();
      t_flush();
      test_done();
   end
endmodule
